// ==== design/eeprom_two_wire_pkg.sv ====
// constants and types shared by the two-wire eeprom target
// assumes a 20 MHz core clock and a link clock taken from the serial clock pin
package eeprom_two_wire_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int NOISE_MAX_NS = 80;
	// a spike of NOISE_MAX_NS can cover two samples, so a level must hold for one more
	localparam int GLITCH_CYC = (NOISE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int WR_TIME_MS = 5;
	localparam int WR_CYC = (WR_TIME_MS * 1000000) / CLK_PERIOD_NS;

	// ==========================================================
	// geometry
	localparam int MEM_WORDS = 8192;
	localparam int ADDR_W = 13;
	localparam int PAGE_BYTES = 32;
	localparam int PAGE_W = 5;
	localparam int SEC_BYTES = 32;
	localparam int WRCNT_W = 20;

	// ==========================================================
	// device address and word address fields
	localparam logic [3:0] NIB_MAIN = 4'hA;
	localparam logic [3:0] NIB_SPECIAL = 4'hB;
	localparam logic [2:0] MODULE_SEL = 3'h0;
	localparam int AREA_LSB = 1;
	localparam int HI_ROW_W = 5;
	localparam logic [1:0] AREA_SECTOR = 2'h0;
	localparam logic [1:0] AREA_LOCK = 2'h2;
	localparam logic [7:0] LOCK_KEY = 8'hFF;
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;

	// ==========================================================
	// reset values
	localparam logic LOCK_RST = 1'b0;
	localparam logic SDA_DRIVE_LEVEL = 1'b0;

	// ==========================================================
	// types
	typedef struct packed {
		logic [3:0] nib;
		logic [2:0] sel;
		logic rd;
	} dev_word_t;

	typedef struct packed {
		logic startEv;
		logic stopEv;
		logic sclFall;
		logic bitEv;
		logic bitVal;
	} link_ev_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_DEV = 7'h02,
		ST_AHI = 7'h04,
		ST_ALO = 7'h08,
		ST_DATA = 7'h10,
		ST_SKIP = 7'h20,
		ST_WRITE = 7'h40
	} state_t;

	typedef enum logic [1:0] {
		TGT_MAIN = 2'h0,
		TGT_SECTOR = 2'h1,
		TGT_LOCK = 2'h2,
		TGT_SERIAL = 2'h3
	} target_t;

endpackage

// ==== design/eeprom_two_wire_target.sv ====
// write-side command engine of a two-wire serial eeprom target
// assumes sclClk and sclIn are the same serial clock wire, sdaIn is the resolved
// data wire, and the bench resolves the open-drain line from sdaOe and sdaOut
// How it works
// - data moves only while clock is low
// - falling data with clock high starts
// - rising data with clock high stops
// - bytes msb first, ack low on ninth
// - standby at reset and after stop
// - nibble 1010 selects main array
// - select bits must match the straps
// - module variant select bits are zero
// - bit zero chooses read or write
// - match acks, mismatch goes to standby
// - nibble 1011 selects sector, lock, serial
// - two address bytes, stop starts write
// - busy write cycle ignores the bus
// - up to 32 bytes per page
// - in-page address wraps inside the page
// - no ack while write is busy
// - sector write uses area bits 00
// - locked sector refuses its data bytes
// - lock byte all ones locks until the next reset
// - protect pin high blocks all writes
// - spikes up to 80 ns ignored by start, stop and ack timing, not by the sclClk bit clock
// - protect pin low writes normally
// - locked sector refuses lock data
module eeprom_two_wire_target #(
	parameter bit MODULE_PKG = 1'b0,
	parameter int WR_CYCLES = eeprom_two_wire_pkg::WR_CYC
) (
	// core clock and reset
	input wire logic clk,
	input wire logic rst,
	// serial link
	input wire logic sclClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// straps and protection
	input wire logic [2:0] selectStrap,
	input wire logic writeProtect,
	// status
	output logic standby,
	output logic writeBusy,
	output logic sectorLocked,
	// array inspection
	input wire logic [eeprom_two_wire_pkg::ADDR_W-1:0] peekAddr,
	input wire logic peekSector,
	output logic [7:0] peekData
);

	// ==========================================================
	// declarations
	localparam logic [1:0] GL_LAST = 2'(eeprom_two_wire_pkg::GLITCH_CYC - 1);
	localparam logic [eeprom_two_wire_pkg::WRCNT_W-1:0] WR_LAST =
		eeprom_two_wire_pkg::WRCNT_W'(WR_CYCLES - 1);
	localparam logic [eeprom_two_wire_pkg::WRCNT_W-1:0] COMMIT_END =
		eeprom_two_wire_pkg::WRCNT_W'(eeprom_two_wire_pkg::PAGE_BYTES);

	logic [1:0] lineA_ff;
	logic [1:0] lineB_ff;
	logic [1:0] lineF_ff;
	logic [1:0] linePrev_ff;
	logic [1:0] glitchCnt_ff [2];
	logic [3:0] pinA_ff;
	logic [3:0] pinB_ff;
	logic linkBit_ff;
	logic linkTgl_ff;
	logic tglA_ff;
	logic tglB_ff;
	logic tglC_ff;
	eeprom_two_wire_pkg::link_ev_t ev;
	eeprom_two_wire_pkg::state_t state_ff;
	eeprom_two_wire_pkg::target_t target_ff;
	eeprom_two_wire_pkg::dev_word_t devWord;
	logic [3:0] bitCnt_ff;
	logic [6:0] shift_ff;
	logic [7:0] rxByte;
	logic byteDone;
	logic selOk;
	logic ackNow;
	logic takeData;
	logic takeLock;
	logic launch;
	logic writeDone;
	logic special_ff;
	logic [7:0] hiByte_ff;
	logic [7:0] row_ff;
	logic [eeprom_two_wire_pkg::PAGE_W-1:0] ptr_ff;
	logic ackPend_ff;
	logic sdaOe_ff;
	logic sdaOut_ff;
	logic [7:0] pageBuf [eeprom_two_wire_pkg::PAGE_BYTES];
	logic [eeprom_two_wire_pkg::PAGE_BYTES-1:0] mask_ff;
	logic lockPend_ff;
	logic locked_ff;
	logic [eeprom_two_wire_pkg::WRCNT_W-1:0] wrCnt_ff;
	logic [eeprom_two_wire_pkg::PAGE_W-1:0] commitIdx;
	logic [7:0] mainMem [eeprom_two_wire_pkg::MEM_WORDS];
	logic [7:0] secMem [eeprom_two_wire_pkg::SEC_BYTES];
	logic standby_ff;
	logic writeBusy_ff;
	logic [7:0] peekData_ff;
	logic [2:0] strapS;
	logic wpS;

	// decides whether a device word names this part in the given area
	function automatic logic devHit(input eeprom_two_wire_pkg::dev_word_t w,
		input logic [3:0] nib, input logic ok);
		devHit = (w.nib == nib) && ok;
	endfunction

	// ==========================================================
	// pin synchronisers and spike filters
	// scl and sda are filtered so that short spikes never form start, stop or edges
	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : gLine
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					lineA_ff[i] <= 1'b1;
					lineB_ff[i] <= 1'b1;
					lineF_ff[i] <= 1'b1;
					glitchCnt_ff[i] <= 2'h0;
				end
				else
				begin
					lineA_ff[i] <= (i == 0) ? sclIn : sdaIn;
					lineB_ff[i] <= lineA_ff[i];
					if (lineB_ff[i] == lineF_ff[i])
						glitchCnt_ff[i] <= 2'h0;
					else if (glitchCnt_ff[i] == GL_LAST)
					begin
						lineF_ff[i] <= lineB_ff[i];
						glitchCnt_ff[i] <= 2'h0;
					end
					else
						glitchCnt_ff[i] <= glitchCnt_ff[i] + 2'h1;
				end
			end
		end
	endgenerate

	// straps and protect pin are quasi-static, two flops are enough
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pinA_ff <= 4'h0;
			pinB_ff <= 4'h0;
		end
		else
		begin
			pinA_ff <= {writeProtect, selectStrap};
			pinB_ff <= pinA_ff;
		end
	end
	assign strapS = pinB_ff[2:0];
	assign wpS = pinB_ff[3];

	// ==========================================================
	// link clock domain
	// bits are taken on the rising serial clock; the toggle marks each new bit
	always_ff @(posedge sclClk or posedge rst)
	begin
		if (rst)
		begin
			linkBit_ff <= 1'b0;
			linkTgl_ff <= 1'b0;
		end
		else
		begin
			linkBit_ff <= sdaIn;
			linkTgl_ff <= ~linkTgl_ff;
		end
	end

	// toggle crossing; linkBit_ff holds for a whole serial period, far longer
	// than the three core cycles the toggle needs to arrive
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tglA_ff <= 1'b0;
			tglB_ff <= 1'b0;
			tglC_ff <= 1'b0;
		end
		else
		begin
			tglA_ff <= linkTgl_ff;
			tglB_ff <= tglA_ff;
			tglC_ff <= tglB_ff;
		end
	end

	// ==========================================================
	// bus events
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			linePrev_ff <= 2'h3;
		else
			linePrev_ff <= lineF_ff;
	end

	// data edges while the clock stays high are start and stop
	always_comb
	begin
		ev.startEv = lineF_ff[0] & linePrev_ff[0] & linePrev_ff[1] & ~lineF_ff[1];
		ev.stopEv = lineF_ff[0] & linePrev_ff[0] & ~linePrev_ff[1] & lineF_ff[1];
		ev.sclFall = linePrev_ff[0] & ~lineF_ff[0];
		ev.bitEv = tglB_ff ^ tglC_ff;
		ev.bitVal = linkBit_ff;
	end

	// ==========================================================
	// bit counter and shifter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			bitCnt_ff <= 4'h0;
			shift_ff <= 7'h00;
		end
		else if (ev.startEv)
			bitCnt_ff <= 4'h0;
		else if (ev.bitEv)
		begin
			bitCnt_ff <= (bitCnt_ff == eeprom_two_wire_pkg::ACK_BIT) ? 4'h0 : bitCnt_ff + 4'h1;
			shift_ff <= {shift_ff[5:0], ev.bitVal};
		end
	end

	// ==========================================================
	// byte decisions
	always_comb
	begin
		rxByte = {shift_ff, ev.bitVal};
		devWord = eeprom_two_wire_pkg::dev_word_t'(rxByte);
		byteDone = ev.bitEv && (bitCnt_ff == eeprom_two_wire_pkg::LAST_DATA_BIT);
		selOk = MODULE_PKG ? (devWord.sel == eeprom_two_wire_pkg::MODULE_SEL)
			: (devWord.sel == strapS);
		ackNow = 1'b0;
		takeData = 1'b0;
		takeLock = 1'b0;
		if (byteDone)
		begin
			unique case (state_ff)
				eeprom_two_wire_pkg::ST_DEV:
					ackNow = devHit(devWord, eeprom_two_wire_pkg::NIB_MAIN, selOk)
						|| devHit(devWord, eeprom_two_wire_pkg::NIB_SPECIAL, selOk);
				eeprom_two_wire_pkg::ST_AHI, eeprom_two_wire_pkg::ST_ALO:
					ackNow = 1'b1;
				eeprom_two_wire_pkg::ST_DATA:
				begin
					unique case (target_ff)
						eeprom_two_wire_pkg::TGT_MAIN:
						begin
							ackNow = 1'b1;
							takeData = 1'b1;
						end
						eeprom_two_wire_pkg::TGT_SECTOR:
						begin
							ackNow = !locked_ff;
							takeData = !locked_ff;
						end
						eeprom_two_wire_pkg::TGT_LOCK:
						begin
							ackNow = !locked_ff;
							takeLock = !locked_ff && (rxByte == eeprom_two_wire_pkg::LOCK_KEY);
						end
						eeprom_two_wire_pkg::TGT_SERIAL:
							ackNow = 1'b0;
					endcase
				end
				eeprom_two_wire_pkg::ST_IDLE, eeprom_two_wire_pkg::ST_SKIP,
				eeprom_two_wire_pkg::ST_WRITE:
					ackNow = 1'b0;
			endcase
		end
		// only a stop ends a write with payload; the pin gates the launch
		launch = ev.stopEv && (state_ff == eeprom_two_wire_pkg::ST_DATA)
			&& ((|mask_ff) || lockPend_ff) && !wpS;
		writeDone = (state_ff == eeprom_two_wire_pkg::ST_WRITE) && (wrCnt_ff == WR_LAST);
		commitIdx = wrCnt_ff[eeprom_two_wire_pkg::PAGE_W-1:0];
	end

	// ==========================================================
	// command sequencer
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_ff <= eeprom_two_wire_pkg::ST_IDLE;
			target_ff <= eeprom_two_wire_pkg::TGT_MAIN;
			special_ff <= 1'b0;
			hiByte_ff <= 8'h00;
			row_ff <= 8'h00;
			ptr_ff <= '0;
		end
		else if (state_ff == eeprom_two_wire_pkg::ST_WRITE)
		begin
			// bus is deaf until the cycle ends
			if (writeDone)
				state_ff <= eeprom_two_wire_pkg::ST_IDLE;
		end
		else if (ev.startEv)
			state_ff <= eeprom_two_wire_pkg::ST_DEV;
		else if (ev.stopEv)
			state_ff <= launch ? eeprom_two_wire_pkg::ST_WRITE : eeprom_two_wire_pkg::ST_IDLE;
		else if (byteDone)
		begin
			unique case (state_ff)
				eeprom_two_wire_pkg::ST_DEV:
				begin
					special_ff <= (devWord.nib == eeprom_two_wire_pkg::NIB_SPECIAL);
					if (!ackNow)
						state_ff <= eeprom_two_wire_pkg::ST_IDLE;
					else if (devWord.rd)
						state_ff <= eeprom_two_wire_pkg::ST_SKIP;
					else
						state_ff <= eeprom_two_wire_pkg::ST_AHI;
				end
				eeprom_two_wire_pkg::ST_AHI:
				begin
					hiByte_ff <= rxByte;
					state_ff <= eeprom_two_wire_pkg::ST_ALO;
				end
				eeprom_two_wire_pkg::ST_ALO:
				begin
					ptr_ff <= rxByte[eeprom_two_wire_pkg::PAGE_W-1:0];
					row_ff <= {hiByte_ff[eeprom_two_wire_pkg::HI_ROW_W-1:0], rxByte[7:5]};
					state_ff <= eeprom_two_wire_pkg::ST_DATA;
					if (!special_ff)
						target_ff <= eeprom_two_wire_pkg::TGT_MAIN;
					else if (hiByte_ff[eeprom_two_wire_pkg::AREA_LSB])
						target_ff <= eeprom_two_wire_pkg::TGT_SERIAL;
					else if (hiByte_ff[eeprom_two_wire_pkg::AREA_LSB+1 -: 2]
						== eeprom_two_wire_pkg::AREA_SECTOR)
						target_ff <= eeprom_two_wire_pkg::TGT_SECTOR;
					else
						target_ff <= eeprom_two_wire_pkg::TGT_LOCK;
				end
				eeprom_two_wire_pkg::ST_DATA:
				begin
					if (takeData)
						ptr_ff <= ptr_ff + eeprom_two_wire_pkg::PAGE_W'(1);
				end
				eeprom_two_wire_pkg::ST_IDLE, eeprom_two_wire_pkg::ST_SKIP,
				eeprom_two_wire_pkg::ST_WRITE:
					state_ff <= state_ff;
			endcase
		end
	end

	// ==========================================================
	// acknowledge driver
	// drives low from the fall after the eighth bit to the fall after the ninth
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ackPend_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			sdaOut_ff <= eeprom_two_wire_pkg::SDA_DRIVE_LEVEL;
		end
		else if (ev.startEv || ev.stopEv)
		begin
			ackPend_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
		end
		else
		begin
			if (byteDone && ackNow)
				ackPend_ff <= 1'b1;
			else if (ev.sclFall && ackPend_ff && !sdaOe_ff)
				ackPend_ff <= 1'b0;
			if (ev.sclFall)
				sdaOe_ff <= !sdaOe_ff && ackPend_ff;
		end
	end

	// ==========================================================
	// page buffer
	// a page of data waits here until the stop; a new start throws it away
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			mask_ff <= '0;
			lockPend_ff <= 1'b0;
		end
		else if (writeDone || (ev.startEv && state_ff != eeprom_two_wire_pkg::ST_WRITE))
		begin
			mask_ff <= '0;
			lockPend_ff <= 1'b0;
		end
		else
		begin
			if (takeData)
				mask_ff[ptr_ff] <= 1'b1;
			if (takeLock)
				lockPend_ff <= 1'b1;
		end
	end

	// buffer data needs no reset, the mask qualifies it
	always_ff @(posedge clk)
	begin
		if (takeData)
			pageBuf[ptr_ff] <= rxByte;
	end

	// ==========================================================
	// self-timed write cycle
	// first PAGE_BYTES cycles copy the buffer, the rest only burn time
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wrCnt_ff <= '0;
		else if (state_ff != eeprom_two_wire_pkg::ST_WRITE)
			wrCnt_ff <= '0;
		else if (!writeDone)
			wrCnt_ff <= wrCnt_ff + eeprom_two_wire_pkg::WRCNT_W'(1);
	end

	// nonvolatile arrays have no reset by nature
	always_ff @(posedge clk)
	begin
		if (state_ff == eeprom_two_wire_pkg::ST_WRITE && wrCnt_ff < COMMIT_END
			&& mask_ff[commitIdx])
		begin
			if (target_ff == eeprom_two_wire_pkg::TGT_MAIN)
				mainMem[{row_ff, commitIdx}] <= pageBuf[commitIdx];
			else if (target_ff == eeprom_two_wire_pkg::TGT_SECTOR)
				secMem[commitIdx] <= pageBuf[commitIdx];
		end
		peekData_ff <= peekSector ? secMem[peekAddr[eeprom_two_wire_pkg::PAGE_W-1:0]]
			: mainMem[peekAddr];
	end

	// lock stays set once written, until the next reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			locked_ff <= eeprom_two_wire_pkg::LOCK_RST;
		else if (writeDone && lockPend_ff)
			locked_ff <= 1'b1;
	end

	// ==========================================================
	// status
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			standby_ff <= 1'b1;
			writeBusy_ff <= 1'b0;
		end
		else
		begin
			standby_ff <= (state_ff == eeprom_two_wire_pkg::ST_IDLE);
			writeBusy_ff <= (state_ff == eeprom_two_wire_pkg::ST_WRITE);
		end
	end

	assign sdaOut = sdaOut_ff;
	assign sdaOe = sdaOe_ff;
	assign standby = standby_ff;
	assign writeBusy = writeBusy_ff;
	assign sectorLocked = locked_ff;
	assign peekData = peekData_ff;

endmodule

// ==== test/eeprom_two_wire_assertions.sv ====
// checker for the two-wire eeprom target, core clock domain only
// assumes it is bound to the target and sees nothing but its ports
module eeprom_two_wire_assertions #(
	parameter int WR_CYCLES = eeprom_two_wire_pkg::WR_CYC
) (
	// core clock and reset
	input wire logic clk,
	input wire logic rst,
	// watched pins
	input wire logic sclIn,
	input wire logic writeProtect,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic standby,
	input wire logic writeBusy,
	input wire logic sectorLocked
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ==========================================================
	// busy cycle length
	logic [19:0] busyCnt_ff;

	// restarts when busy drops so each write cycle is measured alone
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			busyCnt_ff <= 20'h00000;
		else if (writeBusy)
			busyCnt_ff <= busyCnt_ff + 20'h00001;
		else
			busyCnt_ff <= 20'h00000;
	end

	// ==========================================================
	// assertions
	drive_level_a: assert property (sdaOe |-> sdaOut == eeprom_two_wire_pkg::SDA_DRIVE_LEVEL)
		else $error("sda driven high");
	ack_hold_a: assert property (sdaOe && sclIn |=> sdaOe)
		else $error("ack released while clock high");
	ack_edge_a: assert property ($changed(sdaOe) |-> !sclIn)
		else $error("sda moved while clock high");
	standby_quiet_a: assert property (standby |-> !sdaOe)
		else $error("sda driven in standby");
	busy_silent_a: assert property (writeBusy |-> !sdaOe)
		else $error("ack during write cycle");
	busy_awake_a: assert property (writeBusy |-> !standby)
		else $error("standby during write cycle");
	protect_block_a: assert property ($rose(writeBusy) |-> !writeProtect)
		else $error("write cycle while protected");
	write_len_a: assert property ($fell(writeBusy) |->
		busyCnt_ff >= WR_CYCLES - 1 && busyCnt_ff <= WR_CYCLES + 2)
		else $error("write cycle length wrong");
	lock_sticky_a: assert property (sectorLocked |=> sectorLocked)
		else $error("sector lock dropped");

	// ==========================================================
	// covers
	cover property ($rose(writeBusy));
	cover property ($rose(sectorLocked));
	cover property ($rose(sdaOe));
endmodule

// ==== test/tb_top.sv ====
// self-checking bench for the two-wire eeprom target with a controller model
// assumes package, target, checker and controller model are compiled first
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========================================================
	// settings
	localparam int WR_CYC_SIM = 400;
	localparam int LIMIT = 60000;
	localparam logic [2:0] STRAP = 3'h5;
	localparam logic [7:0] DEV_MAIN = {eeprom_two_wire_pkg::NIB_MAIN, STRAP, 1'b0};
	localparam logic [7:0] DEV_SPEC = {eeprom_two_wire_pkg::NIB_SPECIAL, STRAP, 1'b0};

	// ==========================================================
	// signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [2:0] selectStrap = STRAP;
	logic writeProtect = 1'b0;
	logic [eeprom_two_wire_pkg::ADDR_W-1:0] peekAddr = 13'h0000;
	logic peekSector = 1'b0;
	logic scl, sdaDrv, sdaWire, sdaOut, sdaOe, standby, writeBusy, sectorLocked;
	logic [7:0] peekData;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;

	// open-drain wire with pull-up
	assign sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);

	always #25 clk = ~clk;

	eeprom_two_wire_target #(.MODULE_PKG(1'b0), .WR_CYCLES(WR_CYC_SIM)) uut (
		.clk(clk), .rst(rst), .sclClk(scl), .sclIn(scl), .sdaIn(sdaWire),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .selectStrap(selectStrap),
		.writeProtect(writeProtect), .standby(standby), .writeBusy(writeBusy),
		.sectorLocked(sectorLocked), .peekAddr(peekAddr), .peekSector(peekSector),
		.peekData(peekData));

	two_wire_controller #(.HALF_NS(400)) ctl (.sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));

	// ==========================================================
	// helpers
	task automatic results();
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask

	// start, device word, two address bytes, n data bytes counting up
	task automatic send(input logic [7:0] dev, hi, lo, input int n, input logic [7:0] base,
		output int acks);
		logic a;
		logic [7:0] b;
		acks = 0;
		ctl.busStart();
		for (int i = 0; i < n + 3; i++)
		begin
			b = (i == 0) ? dev : (i == 1) ? hi : (i == 2) ? lo : base + 8'(i - 3);
			ctl.sendByte(b, a);
			acks += int'(a === 1'b1);
		end
	endtask

	task automatic peek(input logic [12:0] addr, input logic sec, input logic [7:0] exp);
		@(posedge clk);
		peekAddr <= addr;
		peekSector <= sec;
		repeat (2) @(posedge clk);
		#1 check("peekData", exp, peekData);
	endtask

	// bounded wait for a write cycle to appear, then to finish
	task automatic finishWrite(input logic expBusy);
		int n;
		n = 0;
		while (writeBusy !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n++;
		end
		check("writeBusy", {7'h00, expBusy}, {7'h00, writeBusy});
		n = 0;
		while (writeBusy !== 1'b0 && n < WR_CYC_SIM + 50)
		begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
		#1 check("standby", 8'h01, {7'h00, standby});
	endtask

	// ==========================================================
	// scenarios
	task automatic t_byte();
		int acks;
		logic a;
		send(DEV_MAIN, 8'h1F, 8'hFF, 1, 8'h3C, acks);
		check("byte acks", 8'h04, 8'(acks));
		ctl.busStop();
		ctl.busStart();
		ctl.sendByte(DEV_MAIN, a);
		check("poll ack busy", 8'h00, {7'h00, a});
		ctl.busStop();
		finishWrite(1'b1);
		ctl.busStart();
		ctl.sendByte(DEV_MAIN, a);
		check("poll ack done", 8'h01, {7'h00, a});
		ctl.busStop();
		peek(13'h1FFF, 1'b0, 8'h3C);
	endtask

	// a false start would drop standby for a couple of cycles, so watch every cycle
	task automatic t_spike();
		int lows;
		lows = 0;
		ctl.spike(80);
		repeat (10)
		begin
			@(posedge clk);
			#1 lows += int'(standby !== 1'b1);
		end
		check("spike standby drops", 8'h00, 8'(lows));
	endtask

	task automatic t_reject();
		logic a;
		for (int i = 0; i < 2; i++)
		begin
			ctl.busStart();
			ctl.sendByte(i == 0 ? {4'hA, STRAP ^ 3'h1, 1'b0} : {4'h5, STRAP, 1'b0}, a);
			check("mismatch ack", 8'h00, {7'h00, a});
			check("mismatch standby", 8'h01, {7'h00, standby});
			ctl.busStop();
		end
		// read direction: address acked, then the target stays off the wire
		ctl.busStart();
		ctl.sendByte({eeprom_two_wire_pkg::NIB_MAIN, STRAP, 1'b1}, a);
		check("read ack", 8'h01, {7'h00, a});
		ctl.sendByte(8'hFF, a);
		check("read silent", 8'h00, {7'h00, a});
		ctl.busStop();
		repeat (4) @(posedge clk);
		#1 check("stop standby", 8'h01, {7'h00, standby});
	endtask

	// start mid page so 34 bytes wrap and overwrite the first two
	task automatic t_page();
		int acks;
		int k;
		send(DEV_MAIN, 8'h09, 8'h3E, 34, 8'h40, acks);
		check("page acks", 8'h25, 8'(acks));
		ctl.busStop();
		finishWrite(1'b1);
		for (int p = 0; p < 32; p++)
		begin
			k = (p + 2) % 32;
			k = (k < 2) ? k + 32 : k;
			peek(13'h0920 | 13'(p), 1'b0, 8'h40 + 8'(k));
		end
	endtask

	task automatic t_cancel_protect();
		int acks;
		send(DEV_MAIN, 8'h1F, 8'hFF, 1, 8'hC3, acks);
		ctl.busStart();
		ctl.busStop();
		finishWrite(1'b0);
		@(posedge clk);
		writeProtect <= 1'b1;
		#1;
		send(DEV_MAIN, 8'h1F, 8'hFF, 1, 8'h77, acks);
		ctl.busStop();
		finishWrite(1'b0);
		peek(13'h1FFF, 1'b0, 8'h3C);
		@(posedge clk);
		writeProtect <= 1'b0;
		#1;
	endtask

	task automatic t_sector();
		int acks;
		send(DEV_SPEC, 8'h00, 8'h03, 1, 8'h5A, acks);
		check("sector acks", 8'h04, 8'(acks));
		ctl.busStop();
		finishWrite(1'b1);
		peek(13'h0003, 1'b1, 8'h5A);
		send(DEV_SPEC, 8'h02, 8'h00, 1, 8'h11, acks);
		check("serial number acks", 8'h03, 8'(acks));
		ctl.busStop();
		send(DEV_SPEC, 8'h04, 8'h00, 1, 8'hFF, acks);
		check("lock acks", 8'h04, 8'(acks));
		ctl.busStop();
		finishWrite(1'b1);
		check("sectorLocked", 8'h01, {7'h00, sectorLocked});
		send(DEV_SPEC, 8'h00, 8'h03, 1, 8'hA5, acks);
		check("locked sector acks", 8'h03, 8'(acks));
		ctl.busStop();
		send(DEV_SPEC, 8'h04, 8'h00, 1, 8'hFF, acks);
		check("relock acks", 8'h03, 8'(acks));
		ctl.busStop();
		peek(13'h0003, 1'b1, 8'h5A);
	endtask

	// ==========================================================
	// main sequence and hang guard
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		#1 check("standby after reset", 8'h01, {7'h00, standby});
		ctl.recover();
		t_spike();
		t_byte();
		t_reject();
		t_page();
		t_cancel_protect();
		t_sector();
		results();
	end

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			err_count++;
			results();
		end
	end
endmodule

bind eeprom_two_wire_target eeprom_two_wire_assertions #(.WR_CYCLES(WR_CYCLES)) chk (
	.clk(clk), .rst(rst), .sclIn(sclIn), .writeProtect(writeProtect), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .standby(standby), .writeBusy(writeBusy), .sectorLocked(sectorLocked));

// ==== test/two_wire_controller.sv ====
// behavioural two-wire bus controller driving the serial clock and data lines
// assumes an open-drain data wire with a pull-up resolved by the bench
module two_wire_controller #(
	parameter int HALF_NS = 400
) (
	// resolved data wire
	input wire logic sdaWire,
	// controller drives
	output logic scl,
	output logic sdaDrv
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus: clock parked high, data released
	initial
	begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	// ==========================================================
	// bus conditions
	task automatic busStart();
		if (scl == 1'b0)
		begin
			#(HALF_NS / 2) sdaDrv = 1'b1;
			#(HALF_NS / 2) scl = 1'b1;
		end
		#(HALF_NS) sdaDrv = 1'b0;
		#(HALF_NS) scl = 1'b0;
	endtask

	task automatic busStop();
		#(HALF_NS / 2) sdaDrv = 1'b0;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS) sdaDrv = 1'b1;
		#(HALF_NS);
	endtask

	// data moves mid low phase, never near an edge, so no false condition
	task automatic bitOut(input logic b, output logic s);
		#(HALF_NS / 2) sdaDrv = b;
		#(HALF_NS / 2) scl = 1'b1;
		#(HALF_NS / 2) s = sdaWire;
		#(HALF_NS / 2) scl = 1'b0;
	endtask

	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitOut(b[i], s);
		bitOut(1'b1, s);
		ack = (s === 1'b0);
	endtask

	// clock out a stuck target, up to nine clock pulses
	task automatic recover();
		for (int i = 0; i < 9 && sdaWire !== 1'b1; i++)
		begin
			#(HALF_NS) scl = 1'b0;
			#(HALF_NS) scl = 1'b1;
		end
	endtask

	// short low pulse on an idle data line, aimed at the spike filter
	task automatic spike(input int ns);
		#(HALF_NS) sdaDrv = 1'b0;
		#(ns) sdaDrv = 1'b1;
	endtask
endmodule
